// *** hdl/ahb_reg_port.v ***
// ahb-lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_port (
  input wire core_clk,
  input wire rstn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  output wire [13:0] rd_addr,
  input wire [31:0] rd_data,
  output wire wr_en,
  output reg [13:0] wr_addr,
  output wire [31:0] wr_data
);
  reg wr_pending;
  wire take;

  // zero wait states: read data is fetched in the address phase
  assign take = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rd_addr = haddr[13:0];
  assign wr_en = wr_pending;
  assign wr_data = hwdata;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pending <= 1'b0;
      wr_addr <= 14'h0000;
      hrdata <= 32'h00000000;
    end else begin
      wr_pending <= take & hwrite;
      if (take) begin
        wr_addr <= haddr[13:0];
      end
      if (take & ~hwrite) begin
        hrdata <= rd_data;
      end
    end
  end
endmodule // ahb_reg_port
`default_nettype wire

// *** hdl/irq_prio_select.v ***
// two-level priority pick of the interrupt forwarded to one processor
`timescale 1ns/1ps
`default_nettype none
module irq_prio_select (
  input wire [15:1] pend,
  input wire [15:1] mask,
  input wire [15:1] force_bits,
  input wire [15:1] level,
  output wire [3:0] irq_num
);
  wire [15:1] live;
  wire [3:0] top1;
  wire [3:0] top0;

  function [3:0] highest;
    input [15:1] v;
    integer i;
    begin
      highest = 4'h0;
      for (i = 1; i <= 15; i = i + 1) begin
        if (v[i]) begin
          highest = i[3:0];
        end
      end
    end
  endfunction

  assign live = (pend & mask) | force_bits;
  assign top1 = highest(live & level);
  assign top0 = highest(live & ~level);
  assign irq_num = (top1 != 4'h0) ? top1 : top0;
endmodule // irq_prio_select
`default_nettype wire

// *** hdl/mp_irq_ctrl.v ***
// multiprocessor interrupt controller with four internal controllers
`timescale 1ns/1ps
`default_nettype none
`include "mp_irq_regs.vh"
// How it works
// - high bus line 1..15 sets pending
// - pending sticks until cleared or acknowledged
// - level register puts line at level 0/1
// - higher line number wins within level
// - level 1 first, then level 0
// - shared priority, per-processor mask and force
// - acknowledge clears the pending bit
// - force raises; acknowledge clears force instead
// - masks reset to all zeros
// - extended lines 16-31 appear as line 10
// - ack of 10 clears 10 and the highest extended line
// - last acknowledged extended number is readable
// - status reads halted; writing 1 restarts
// - all but processor 0 halted after reset
// - four register sets at 0x1000 strides
// - extra controller count field reads N
// - processors start on controller 0, reassignable
// - lock bit freezes select registers
// - per-processor writes only from assigned controller
// - force clears only from assigned controller
// - any-controller force set under flag
module mp_irq_ctrl (
  input wire core_clk,
  input wire rstn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire [31:0] bus_request_line,
  output wire [15:0] cpu_irq_num,
  input wire [3:0] cpu_ack,
  input wire [15:0] cpu_ack_num,
  input wire [3:0] cpu_halt_event,
  output reg [3:0] cpu_halted,
  output reg [3:0] cpu_restart
);
  // ****************************************************************
  // storage
  // ****************************************************************
  reg [15:1] level;
  reg [31:1] pending;
  reg ext_enable;
  reg lock;
  reg force_set_from_any_ctrl;
  reg [1:0] ctrl_sel [0:3];
  reg [31:1] mask [0:3];
  reg [15:1] force_r [0:3];
  reg [4:0] ext_ack [0:3];

  wire [13:0] rd_addr;
  reg [31:0] rd_data;
  wire wr_en;
  wire [13:0] wr_addr;
  wire [31:0] wr_data;
  wire [1:0] wr_ctrl;
  wire [11:0] wr_off;
  wire [1:0] wr_idx;
  wire [1:0] rd_idx;
  wire [3:0] ext_any;
  wire [4:0] ext_top [0:3];
  integer c;
  reg [31:1] next_pending;
  reg [3:0] ack_k;

  function [4:0] highest_ext;
    input [31:16] v;
    integer i;
    begin
      highest_ext = 5'h00;
      for (i = 16; i <= 31; i = i + 1) begin
        if (v[i]) begin
          highest_ext = i[4:0];
        end
      end
    end
  endfunction

  ahb_reg_port bus_port (
    .core_clk(core_clk),
    .rstn(rstn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // address bits 13:12 pick the internal controller
  assign wr_ctrl = wr_addr[13:12];
  assign wr_off = wr_addr[11:0];
  assign wr_idx = wr_off[3:2];
  assign rd_idx = rd_addr[3:2];

  // ****************************************************************
  // per-processor forwarding
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : per_cpu
      // extended lines reach the processor as line 10
      assign ext_top[g] = highest_ext(pending[31:16] & mask[g][31:16]);
      assign ext_any[g] = ext_enable & (ext_top[g] != 5'h00);
      irq_prio_select prio (
        .pend(pending[15:1] | ({14'h0000, ext_any[g]} << 9)),
        .mask(mask[g][15:1] | ({14'h0000, ext_any[g]} << 9)),
        .force_bits(force_r[g]),
        .level(level),
        .irq_num(cpu_irq_num[4*g+3:4*g])
      );
    end
  endgenerate

  // ****************************************************************
  // read mux
  // ****************************************************************
  always @* begin
    rd_data = 32'h00000000;
    if (rd_addr[11:0] == `OFF_LEVEL) begin
      rd_data = {16'h0000, level, 1'b0};
    end else if (rd_addr[11:0] == `OFF_PENDING) begin
      rd_data = {pending, 1'b0};
    end else if (rd_addr[11:0] == `OFF_STATUS) begin
      rd_data = {28'h0000000, cpu_halted};
    end else if (rd_addr[11:0] == `OFF_ASYM_CTRL) begin
      rd_data = {`EXTRA_CTRL_COUNT, 26'h0000000, force_set_from_any_ctrl, lock};
    end else if (rd_addr[11:0] == `OFF_EXT_CFG) begin
      rd_data = {31'h00000000, ext_enable};
    end else if (rd_addr[11:0] == `OFF_SELECT) begin
      rd_data = {24'h000000, ctrl_sel[3], ctrl_sel[2], ctrl_sel[1], ctrl_sel[0]};
    end else if (rd_addr[11:4] == `OFF_MASK_BASE >> 4) begin
      rd_data = {mask[rd_idx], 1'b0};
    end else if (rd_addr[11:4] == `OFF_FORCE_BASE >> 4) begin
      rd_data = {16'h0000, force_r[rd_idx], 1'b0};
    end else if (rd_addr[11:4] == `OFF_EXT_ACK_BASE >> 4) begin
      rd_data = {27'h0000000, ext_ack[rd_idx]};
    end
  end

  // ****************************************************************
  // pending register
  // ****************************************************************
  always @* begin
    next_pending = pending;
    ack_k = 4'h0;
    if (wr_en && wr_off == `OFF_PENDING) begin
      next_pending = wr_data[31:1];
    end else if (wr_en && wr_off == `OFF_CLEAR) begin
      next_pending = pending & ~wr_data[31:1];
    end
    for (c = 0; c < 4; c = c + 1) begin
      ack_k = cpu_ack_num[4*c+3 -: 4];
      if (cpu_ack[c] && ack_k != 4'h0 && !force_r[c][ack_k]) begin
        next_pending[ack_k] = 1'b0;
        if (ack_k == `EXT_LINE && ext_any[c]) begin
          next_pending[ext_top[c]] = 1'b0;
        end
      end
    end
    // new requests win over any clear in the same cycle
    next_pending[15:1] = next_pending[15:1] | bus_request_line[15:1];
    if (ext_enable) begin
      next_pending[31:16] = next_pending[31:16] | bus_request_line[31:16];
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pending <= 31'h00000000;
    end else begin
      pending <= next_pending;
    end
  end

  // ****************************************************************
  // control registers and per-processor state
  // ****************************************************************
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      level <= 15'h0000;
      ext_enable <= 1'b0;
      lock <= 1'b0;
      force_set_from_any_ctrl <= 1'b0;
      cpu_halted <= `HALT_RESET;
      cpu_restart <= 4'h0;
      for (c = 0; c < 4; c = c + 1) begin
        ctrl_sel[c] <= 2'b00;
        mask[c] <= 31'h00000000;
        force_r[c] <= 15'h0000;
        ext_ack[c] <= 5'h00;
      end
    end else begin
      cpu_restart <= 4'h0;
      if (wr_en && wr_off == `OFF_LEVEL) begin
        level <= wr_data[15:1];
      end
      if (wr_en && wr_off == `OFF_EXT_CFG) begin
        ext_enable <= wr_data[0];
      end
      if (wr_en && wr_off == `OFF_ASYM_CTRL) begin
        // lock is sticky until reset so a stray write cannot undo it
        lock <= lock | wr_data[`ASYM_LOCK_BIT];
        force_set_from_any_ctrl <= wr_data[`ASYM_ICF_BIT];
      end
      for (c = 0; c < 4; c = c + 1) begin
        if (wr_en && wr_off == `OFF_SELECT && !lock) begin
          ctrl_sel[c] <= wr_data[2*c+1 -: 2];
        end
        if (wr_en && wr_off == `OFF_MASK_BASE + {8'h00, c[1:0], 2'b00}
            && ctrl_sel[c] == wr_ctrl) begin
          mask[c] <= wr_data[31:1];
        end
        if (wr_en && wr_off == `OFF_EXT_ACK_BASE + {8'h00, c[1:0], 2'b00}
            && ctrl_sel[c] == wr_ctrl) begin
          ext_ack[c] <= wr_data[4:0];
        end else if (cpu_ack[c] && cpu_ack_num[4*c+3 -: 4] == `EXT_LINE && ext_any[c]
                     && !force_r[c][`EXT_LINE]) begin
          ext_ack[c] <= ext_top[c];
        end
        force_r[c] <= next_force(c[1:0]);
        if (cpu_halt_event[c]) begin
          cpu_halted[c] <= 1'b1;
        end else if (wr_en && wr_off == `OFF_STATUS && wr_data[c]
                     && cpu_halted[c] && ctrl_sel[c] == wr_ctrl) begin
          cpu_halted[c] <= 1'b0;
          cpu_restart[c] <= 1'b1;
        end
      end
    end
  end

  // force bits: clears from ack or the assigned controller, sets win
  function [15:1] next_force;
    input [1:0] n;
    reg [15:1] f;
    reg [3:0] k;
    reg own;
    begin
      f = force_r[n];
      k = cpu_ack_num[4*n+3 -: 4];
      own = (ctrl_sel[n] == wr_ctrl);
      if (cpu_ack[n] && k != 4'h0) begin
        f[k] = 1'b0;
      end
      if (wr_en && wr_off == `OFF_FORCE_BASE + {8'h00, n, 2'b00}) begin
        if (own) begin
          f = f & ~wr_data[31:17];
        end
        if (own || force_set_from_any_ctrl) begin
          f = f | wr_data[15:1];
        end
      end
      next_force = f;
    end
  endfunction
endmodule // mp_irq_ctrl
`default_nettype wire

// *** hdl/mp_irq_regs.vh ***
// register offsets, field positions, reset values and sizes of the interrupt controller
`ifndef MP_IRQ_REGS_VH
`define MP_IRQ_REGS_VH
`define NUM_CPU 4
`define NUM_CTRL 4
`define EXTRA_CTRL_COUNT 4'h3
`define OFF_LEVEL 12'h000
`define OFF_PENDING 12'h004
`define OFF_CLEAR 12'h00C
`define OFF_STATUS 12'h010
`define OFF_ASYM_CTRL 12'h020
`define OFF_EXT_CFG 12'h024
`define OFF_SELECT 12'h030
`define OFF_MASK_BASE 12'h040
`define OFF_FORCE_BASE 12'h080
`define OFF_EXT_ACK_BASE 12'h0C0
`define ASYM_LOCK_BIT 0
`define ASYM_ICF_BIT 1
`define ASYM_COUNT_MSB 31
`define ASYM_COUNT_LSB 28
`define FORCE_CLR_LSB 16
`define EXT_LINE 4'hA
`define EXT_FIRST 16
`define HALT_RESET 4'hE
`endif

// *** testbench/cpu_side_model.sv ***
// processor-side model that takes forwarded interrupts and acknowledges them
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [15:0] cpu_irq_num,
  input wire logic [3:0] ack_en,
  input wire logic [3:0] delay,
  output logic [3:0] cpu_ack,
  output logic [15:0] cpu_ack_num
);
  logic [3:0] wait_cnt [4];
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_ack <= 4'h0;
      cpu_ack_num <= 16'hFFFF;
      for (int n = 0; n < 4; n++) wait_cnt[n] <= 4'h0;
    end else begin
      for (int n = 0; n < 4; n++) begin
        logic go;
        // skip the cycle after a pulse: the cleared number only shows one edge later
        go = ack_en[n] && !cpu_ack[n] && cpu_irq_num[4*n +: 4] != 4'h0 && wait_cnt[n] >= delay;
        if (cpu_irq_num[4*n +: 4] == 4'h0 || cpu_ack[n]) wait_cnt[n] <= 4'h0;
        else if (wait_cnt[n] != 4'hF) wait_cnt[n] <= wait_cnt[n] + 4'h1;
        cpu_ack[n] <= go;
        // number is only meaningful with the strobe, so it is driven inverted otherwise
        cpu_ack_num[4*n +: 4] <= go ? cpu_irq_num[4*n +: 4] : ~cpu_irq_num[4*n +: 4];
      end
    end
  end
endmodule // cpu_side_model
`default_nettype wire

// *** testbench/mp_irq_sva.sv ***
// port-level assertions for the multiprocessor interrupt controller
`timescale 1ns/1ps
`default_nettype none
module mp_irq_sva (
  input wire core_clk,
  input wire rstn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] bus_request_line,
  input wire [15:0] cpu_irq_num,
  input wire [3:0] cpu_ack,
  input wire [3:0] cpu_halt_event,
  input wire [3:0] cpu_halted,
  input wire [3:0] cpu_restart
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // a write lands two edges after its address phase is taken
  wire wr_take = hsel && htrans[1] && hwrite && hready;
  property p_reset_halt;
    $rose(rstn) |-> cpu_halted == 4'hE;
  endproperty
  a_reset_halt: assert property (p_reset_halt) else $error("halt state wrong after reset");
  property p_reset_irq;
    $rose(rstn) |-> cpu_irq_num == 16'h0000;
  endproperty
  a_reset_irq: assert property (p_reset_irq) else $error("interrupt forwarded after reset");
  property p_halt_set;
    cpu_halt_event != 4'h0 |=> (cpu_halted & $past(cpu_halt_event)) == $past(cpu_halt_event);
  endproperty
  a_halt_set: assert property (p_halt_set) else $error("halt event not recorded");
  property p_cpu0_run;
    $rose(cpu_halted[0]) |-> $past(cpu_halt_event[0]);
  endproperty
  a_cpu0_run: assert property (p_cpu0_run) else $error("processor 0 halted without event");
  property p_restart_cause;
    cpu_restart != 4'h0 |-> ($past(cpu_halted) & cpu_restart) == cpu_restart && $past(wr_take, 2);
  endproperty
  a_restart_cause: assert property (p_restart_cause) else $error("restart without cause");
  property p_restart_pulse;
    cpu_restart != 4'h0 |=> (cpu_restart & $past(cpu_restart)) == 4'h0;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("restart longer than one cycle");
  property p_irq_cause;
    !$stable(cpu_irq_num) |-> $past(bus_request_line[31:1] != 31'h0) || $past(cpu_ack != 4'h0)
      || $past(wr_take, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("forwarded number changed uncaused");
  property p_bus_ok;
    hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus response not okay");
endmodule // mp_irq_sva
bind mp_irq_ctrl mp_irq_sva u_sva (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .bus_request_line(bus_request_line), .cpu_irq_num(cpu_irq_num), .cpu_ack(cpu_ack),
  .cpu_halt_event(cpu_halt_event), .cpu_halted(cpu_halted), .cpu_restart(cpu_restart));
`default_nettype wire

// *** testbench/multiprocessor_irq_controller_bench.sv ***
// self-checking bench for the multiprocessor interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "mp_irq_regs.vh"
module multiprocessor_irq_controller_bench;
  logic core_clk, rstn, hsel, hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, bus_request_line, q;
  logic [3:0] cpu_halt_event, ack_en, delay;
  wire hready, hresp;
  wire [31:0] hrdata;
  wire [15:0] cpu_irq_num, cpu_ack_num;
  wire [3:0] cpu_ack, cpu_halted, cpu_restart;
  int n_errors = 0;
  int n_checks = 0;
  typedef struct packed {logic [15:0] lvl, pnd, msk; logic [3:0] num;} row_t;
  row_t rows [6] = '{'{16'h0000, 16'h0088, 16'hFFFE, 4'h7}, '{16'h0008, 16'h0088, 16'hFFFE, 4'h3},
    '{16'h0008, 16'h0088, 16'h0080, 4'h7}, '{16'hFFFE, 16'h8002, 16'hFFFE, 4'hF},
    '{16'h0000, 16'h0088, 16'h0000, 4'h0}, '{16'h0000, 16'h0002, 16'h0002, 4'h1}};
  mp_irq_ctrl i_dut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .bus_request_line(bus_request_line),
    .cpu_irq_num(cpu_irq_num), .cpu_ack(cpu_ack), .cpu_ack_num(cpu_ack_num),
    .cpu_halt_event(cpu_halt_event), .cpu_halted(cpu_halted), .cpu_restart(cpu_restart));
  cpu_side_model i_cpu (.core_clk(core_clk), .rstn(rstn), .cpu_irq_num(cpu_irq_num),
    .ack_en(ack_en), .delay(delay), .cpu_ack(cpu_ack), .cpu_ack_num(cpu_ack_num));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (hready !== 1'b1) begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] c, input logic [11:0] o,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {16'h0000, c, o};
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= w ? d : ~d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [3:0] c, input logic [11:0] o, input logic [31:0] d);
    bus(1'b1, c, o, d);
  endtask
  task automatic rd(input logic [3:0] c, input logic [11:0] o, input logic [31:0] e);
    bus(1'b0, c, o, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic wait_irq(input logic [15:0] e);
    int k;
    k = 0;
    // let the edge that launched the last bus write or pulse settle first
    #1;
    while (cpu_irq_num !== e && k < 40) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk({16'h0000, cpu_irq_num}, {16'h0000, e});
    if (cpu_irq_num !== e) final_report();
  endtask
  task automatic pulse_line(input logic [31:0] v);
    bus_request_line <= v;
    @(posedge core_clk);
    bus_request_line <= 32'h0000_0000;
  endtask
  initial begin
    rstn = 1'b0; hsel = 1'b0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2;
    haddr = 32'h0000_0000; hwdata = 32'h0000_0000; bus_request_line = 32'h0000_0000;
    cpu_halt_event = 4'h0; ack_en = 4'h0; delay = 4'h0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    chk(cpu_halted, 4'hE);
    rd(4'h0, `OFF_MASK_BASE, 32'h0000_0000);
    rd(4'h0, `OFF_ASYM_CTRL, {`EXTRA_CTRL_COUNT, 28'h0});
    rd(4'h0, 12'h0FC, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(4'h0, `OFF_LEVEL, rows[i].lvl);
      wr(4'h0, `OFF_MASK_BASE, rows[i].msk);
      wr(4'h0, `OFF_PENDING, rows[i].pnd);
      #1 chk(cpu_irq_num, rows[i].num);
    end
    $display("test priority table done");
    wr(4'h0, `OFF_PENDING, 32'h0000_0000);
    wr(4'h0, `OFF_MASK_BASE + 12'h004, 32'h0000_0020);
    pulse_line(32'h0000_0020);
    wait_irq(16'h0050);
    ack_en <= 4'h3;
    delay <= 4'h3;
    wait_irq(16'h0000);
    rd(4'h0, `OFF_PENDING, 32'h0000_0000);
    delay <= 4'h0;
    wr(4'h0, `OFF_PENDING, 32'h0000_0008);
    wr(4'h0, `OFF_FORCE_BASE, 32'h0000_0008);
    wait_irq(16'h0000);
    rd(4'h0, `OFF_FORCE_BASE, 32'h0000_0000);
    rd(4'h0, `OFF_PENDING, 32'h0000_0008);
    wr(4'h0, `OFF_CLEAR, 32'hFFFF_FFFE);
    ack_en <= 4'h0;
    $display("test acknowledge done");
    rd(4'h0, `OFF_SELECT, 32'h0000_0000);
    wr(4'h0, `OFF_SELECT, 32'h0000_0001);
    wr(4'h0, `OFF_MASK_BASE, 32'h0000_0010);
    rd(4'h2, `OFF_MASK_BASE, 32'h0000_0002);
    wr(4'h1, `OFF_MASK_BASE, 32'h0000_0010);
    rd(4'h3, `OFF_MASK_BASE, 32'h0000_0010);
    wr(4'h0, `OFF_FORCE_BASE, 32'h0000_0040);
    rd(4'h1, `OFF_FORCE_BASE, 32'h0000_0000);
    wr(4'h0, `OFF_ASYM_CTRL, 32'h0000_0003);
    wr(4'h0, `OFF_FORCE_BASE, 32'h0000_0040);
    rd(4'h1, `OFF_FORCE_BASE, 32'h0000_0040);
    wr(4'h0, `OFF_FORCE_BASE, 32'h0040_0000);
    rd(4'h1, `OFF_FORCE_BASE, 32'h0000_0040);
    wr(4'h1, `OFF_FORCE_BASE, 32'h0040_0000);
    rd(4'h0, `OFF_FORCE_BASE, 32'h0000_0000);
    wr(4'h0, `OFF_SELECT, 32'h0000_0000);
    rd(4'h0, `OFF_SELECT, 32'h0000_0001);
    $display("test controller split done");
    wr(4'h0, `OFF_EXT_CFG, 32'h0000_0001);
    wr(4'h1, `OFF_MASK_BASE, 32'h0010_0000);
    pulse_line(32'h0010_0000);
    wait_irq(16'h000A);
    ack_en <= 4'h1;
    wait_irq(16'h0000);
    rd(4'h1, `OFF_EXT_ACK_BASE, 32'h0000_0014);
    rd(4'h0, `OFF_PENDING, 32'h0000_0000);
    $display("test extended lines done");
    wr(4'h0, `OFF_STATUS, 32'h0000_0004);
    #1 chk(cpu_restart, 4'h4);
    wr(4'h1, `OFF_STATUS, 32'h0000_0008);
    rd(4'h0, `OFF_STATUS, 32'h0000_000A);
    cpu_halt_event <= 4'h1;
    @(posedge core_clk);
    cpu_halt_event <= 4'h0;
    #1 chk(cpu_halted, 4'hB);
    $display("test status done");
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    chk(cpu_halted, 4'hE);
    rd(4'h0, `OFF_SELECT, 32'h0000_0000);
    rd(4'h0, `OFF_MASK_BASE, 32'h0000_0000);
    $display("test second reset done");
    final_report();
  end
endmodule // multiprocessor_irq_controller_bench
`default_nettype wire
